// [logic/ssp_setpoint_shift.v]
`include "ssp_regs.vh"

module ssp_setpoint_shift (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Setpoint outputs
  output reg [15:0] eff_setpoint,
  output reg [7:0] cur_shift,
  output reg act_tx_valid,
  output reg [15:0] act_tx_value,
  output reg nv_write
);

  reg [4:0] ctrl;
  reg [15:0] init_basic;
  reg [15:0] nv_basic;
  reg [15:0] tmp_basic;
  reg tmp_valid;
  reg [15:0] basic_obj;
  reg basic_obj_valid;
  reg [15:0] limits;
  reg [15:0] frost;
  reg [15:0] heat;
  reg [15:0] next_eff;
  reg [7:0] next_shift;
  reg [15:0] basic_used;
  reg [15:0] raw_eff;
  reg signed [7:0] spec;
  reg signed [7:0] lim_hi;
  reg signed [7:0] lim_lo;
  reg signed [23:0] prod;

  wire wr = psel && penable && pwrite;
  wire perm = ctrl[`SSP_CTRL_PERM_ACCEPT];
  wire absolute = ctrl[`SSP_CTRL_ABSOLUTE];
  wire [15:0] step = ctrl[`SSP_CTRL_STEP_HALF] ? `SSP_STEP_HALF : `SSP_STEP_FINE;
  wire wr_basic = wr && (paddr == `SSP_ADDR_BASIC || paddr == `SSP_ADDR_ACTIVE);
  wire wr_spec = wr && (paddr == `SSP_ADDR_SHIFT_SPEC);
  wire wr_event = wr && (paddr == `SSP_ADDR_EVENT);
  wire mode_sw = wr_event && (pwdata[`SSP_EV_MODE_SW] || pwdata[`SSP_EV_HC_SW]);
  wire bus_fail = wr_event && pwdata[`SSP_EV_BUS_FAIL];
  wire mapped = (paddr <= `SSP_ADDR_STATUS) && (paddr[1:0] == 2'b00);

  // Zero-wait slave; unmapped addresses flag an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SSP_RST_CTRL;
      limits <= `SSP_RST_LIMITS;
      frost <= `SSP_RST_FROST;
      heat <= `SSP_RST_HEAT;
      init_basic <= `SSP_RST_BASIC;
    end else if (wr) begin
      case (paddr)
        `SSP_ADDR_CTRL: ctrl <= pwdata[4:0];
        `SSP_ADDR_LIMITS: limits <= pwdata[15:0];
        `SSP_ADDR_PROT: begin
          frost <= pwdata[15:0];
          heat <= pwdata[31:16];
        end
        default: ;
      endcase
    end
  end

  // Non-volatile basic copy; reset leaves it alone as a real EEPROM would
  // Permanent write replaces initial value
  // Storage choice follows the permanent setting
  always @(posedge pclk) begin
    if (wr_basic && perm) begin
      nv_basic <= pwdata[15:0];
    end
  end

  // Store write strobe, one cycle per accepted permanent write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_write <= 1'b0;
    end else begin
      nv_write <= wr_basic && perm;
    end
  end

  // Temporary setpoint
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmp_basic <= 16'h0000;
      tmp_valid <= 1'b0;
    end else if (wr_basic && !perm) begin
      tmp_basic <= pwdata[15:0];
      tmp_valid <= 1'b1;
    // Temporary value discarded on switchover or bus fail
    end else if (mode_sw || bus_fail) begin
      tmp_valid <= 1'b0;
    end
  end

  // Readable input object: empty after reset until a new telegram
  // No preload of restored value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      basic_obj <= 16'h0000;
      basic_obj_valid <= 1'b0;
    end else if (wr_basic) begin
      basic_obj <= pwdata[15:0];
      basic_obj_valid <= 1'b1;
    end
  end

  // Flag that the store holds a value; part of the store, so no reset
  // Stored value outlives a device reset
  reg nv_used;
  always @(posedge pclk) begin
    if (wr_basic && perm) begin
      nv_used <= 1'b1;
    end
  end

  // Shift target: clamp to limits (low byte upper, high byte lower)
  always @* begin
    spec = $signed(pwdata[7:0]);
    lim_hi = $signed(limits[7:0]);
    lim_lo = $signed(limits[15:8]);
    next_shift = cur_shift;
    if (spec > lim_hi) begin
      next_shift = lim_hi;
    end else if (spec < lim_lo) begin
      next_shift = lim_lo;
    end else begin
      next_shift = spec;
    end
  end

  // Shift count, volatile
  // Cleared on any reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_shift <= 8'h00;
    end else if (absolute || bus_fail) begin
      cur_shift <= 8'h00;
    end else if (wr_spec) begin
      cur_shift <= next_shift;
    end else if (!ctrl[`SSP_CTRL_PERM_SHIFT] && (mode_sw || wr_basic)) begin
      cur_shift <= 8'h00;
    end
  end

  // Effective setpoint
  always @* begin
    // Stored value replaces the initial one once written
    basic_used = nv_used ? nv_basic : init_basic;
    if (!perm && tmp_valid) begin
      basic_used = tmp_basic;
    end
    // Step width 0.1 K or 0.5 K
    prod = $signed(cur_shift) * $signed({1'b0, step});
    raw_eff = basic_used + prod[15:0];
    next_eff = raw_eff;
    // Bounded by frost and heat protection
    if ($signed(raw_eff) > $signed(heat)) begin
      next_eff = heat;
    end else if ($signed(raw_eff) < $signed(frost)) begin
      next_eff = frost;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eff_setpoint <= `SSP_RST_BASIC;
    end else begin
      eff_setpoint <= next_eff;
    end
  end

  // Active-mode feedback; basic object never sent
  // Basic object receive-only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_tx_valid <= 1'b0;
      act_tx_value <= 16'h0000;
    end else begin
      act_tx_valid <= absolute && ctrl[`SSP_CTRL_ACT_TX] && (next_eff != eff_setpoint);
      act_tx_value <= next_eff;
    end
  end

  // Read mux
  always @* begin
    case (paddr)
      `SSP_ADDR_CTRL: prdata = {27'h0000000, ctrl};
      `SSP_ADDR_BASIC: prdata = {16'h0000, basic_obj};
      `SSP_ADDR_ACTIVE: prdata = {16'h0000, basic_obj};
      `SSP_ADDR_SHIFT_SPEC: prdata = {24'h000000, cur_shift};
      `SSP_ADDR_SHIFT_CUR: prdata = {24'h000000, cur_shift};
      `SSP_ADDR_EFFECTIVE: prdata = {16'h0000, eff_setpoint};
      `SSP_ADDR_LIMITS: prdata = {16'h0000, limits};
      `SSP_ADDR_PROT: prdata = {heat, frost};
      `SSP_ADDR_NV_BASIC: prdata = {16'h0000, nv_used ? nv_basic : init_basic};
      `SSP_ADDR_STATUS: prdata = {29'h00000000, nv_used, tmp_valid, basic_obj_valid};
      default: prdata = 32'h00000000;
    endcase
  end

endmodule

// [pkg/ssp_regs.vh]
`ifndef SSP_REGS_VH
`define SSP_REGS_VH
// Register byte addresses
`define SSP_ADDR_CTRL 12'h000
`define SSP_ADDR_BASIC 12'h004
`define SSP_ADDR_ACTIVE 12'h008
`define SSP_ADDR_SHIFT_SPEC 12'h00C
`define SSP_ADDR_SHIFT_CUR 12'h010
`define SSP_ADDR_EFFECTIVE 12'h014
`define SSP_ADDR_LIMITS 12'h018
`define SSP_ADDR_PROT 12'h01C
`define SSP_ADDR_EVENT 12'h020
`define SSP_ADDR_NV_BASIC 12'h024
`define SSP_ADDR_STATUS 12'h028
// CTRL field positions
`define SSP_CTRL_PERM_ACCEPT 0
`define SSP_CTRL_ABSOLUTE 1
`define SSP_CTRL_STEP_HALF 2
`define SSP_CTRL_PERM_SHIFT 3
`define SSP_CTRL_ACT_TX 4
// EVENT field positions (write-one pulses)
`define SSP_EV_MODE_SW 0
`define SSP_EV_HC_SW 1
`define SSP_EV_BUS_FAIL 2
// Step widths in 0.1 K units
`define SSP_STEP_FINE 16'h0001
`define SSP_STEP_HALF 16'h0005
// Reset values (temperatures in 0.1 K units, limits in shift steps)
`define SSP_RST_CTRL 5'h00
`define SSP_RST_BASIC 16'h00D2
`define SSP_RST_LIMITS 16'hF60A
`define SSP_RST_FROST 16'h0046
`define SSP_RST_HEAT 16'h015E
`endif

// [bench/ssp_chk_monitor.sv]
module ssp_chk (
  // Bus side
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // Results
  input wire [15:0] eff_setpoint,
  input wire [7:0] cur_shift,
  input wire act_tx_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Decoded writes and a shadow of the mode bits
  wire wr = psel && penable && pwrite;
  wire sp = wr && paddr == 12'h00C;
  wire ev = wr && paddr == 12'h020 && (pwdata[0] || pwdata[1]);
  wire signed [7:0] s = pwdata[7:0];
  reg [4:0] ct;
  always @(posedge pclk or negedge presetn)
    if (!presetn) ct <= 5'h00;
    else if (wr && paddr == 12'h000) ct <= pwdata[4:0];
  property p_jump; sp && !ct[1] && s >= -10 && s <= 10 |=> cur_shift == $past(s); endproperty
  a_jump: assert property (p_jump) else $error("shift not taken directly");
  property p_clamp; sp && !ct[1] && (s > 10 || s < -10) |=> cur_shift == ($past(s) > 0 ? 8'h0A : 8'hF6); endproperty
  a_clamp: assert property (p_clamp) else $error("shift not clamped");
  property p_abs; sp && ct[1] |=> $stable(cur_shift); endproperty
  a_abs: assert property (p_abs) else $error("shift taken in absolute mode");
  property p_rst; $rose(presetn) |-> cur_shift == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("shift survived reset");
  property p_clr; ev && !ct[3] |=> cur_shift == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("shift not cleared");
  property p_keep; ev && ct[3] && !pwdata[2] |=> $stable(cur_shift); endproperty
  a_keep: assert property (p_keep) else $error("permanent shift lost");
  property p_chg; !$stable(cur_shift) |-> $past(wr) || ct[1]; endproperty
  a_chg: assert property (p_chg) else $error("shift moved without cause");
  property p_prot; eff_setpoint >= 16'h0046 && eff_setpoint <= 16'h015E; endproperty
  a_prot: assert property (p_prot) else $error("setpoint outside protection");
  property p_tx; act_tx_valid |-> ct[1] && ct[4]; endproperty
  a_tx: assert property (p_tx) else $error("setpoint sent in relative mode");
endmodule
bind ssp_setpoint_shift ssp_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .eff_setpoint, .cur_shift, .act_tx_valid);

// [bench/ssp_ext_model.sv]
module ssp_ext_model (
  // Controller feedback
  input wire pclk,
  input wire [7:0] cur_shift,
  input wire act_tx_valid,
  input wire [15:0] act_tx_value
);
  timeunit 1ns;
  timeprecision 1ns;
  int n_tx = 0;
  logic [15:0] last_tx = 16'h0000;
  logic [7:0] shown = 8'h00;
  always @(posedge pclk) begin
    shown <= cur_shift;
    if (act_tx_valid === 1'b1) begin
      n_tx <= n_tx + 1;
      last_tx <= act_tx_value;
    end
  end
endmodule

// [bench/tb_setpoint_shift_persistence.sv]
module tb_setpoint_shift_persistence;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, act_tx_valid, nv_write, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hFF4D;
  logic [15:0] eff_setpoint, act_tx_value;
  logic [7:0] cur_shift;
  int n_mismatch = 0, total_checks = 0, cyc = 0, n_nv = 0, bs = 210, sh = 0, stp = 1;
  int tab[6] = '{1, 2, -1, 10, 100, -128};
  always #25 pclk = ~pclk;
  ssp_setpoint_shift dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .eff_setpoint, .cur_shift, .act_tx_valid, .act_tx_value, .nv_write);
  ssp_ext_model ext_u (.pclk, .cur_shift, .act_tx_valid, .act_tx_value);
  // Store pulses and hang guard
  always @(posedge pclk) begin
    cyc++;
    if (nv_write === 1'b1) n_nv++;
    if (cyc > 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Effective value, clamped by frost and heat
  function automatic int eff_m();
    int e;
    e = bs + sh * stp;
    return e < 70 ? 70 : (e > 350 ? 350 : e);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Outputs checked three edges after the write
  task automatic see();
    repeat (3) @(posedge pclk);
    #1;
    chk($signed(cur_shift), sh);
    chk(eff_setpoint, eff_m());
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Store starts erased at power-up
  initial dut_u.nv_used = 1'b0;
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    see();
    apb(1, 12'h000, 32'h4);
    stp = 5;
    foreach (tab[i]) begin
      apb(1, 12'h00C, tab[i]);
      sh = tab[i] > 10 ? 10 : (tab[i] < -10 ? -10 : tab[i]);
      see();
    end
    apb(1, 12'h000, 32'h8);
    stp = 1;
    repeat (4) begin
      sh = int'(rnd() % 21) - 10;
      apb(1, 12'h00C, sh);
      see();
    end
    apb(1, 12'h020, 32'h1);
    see();
    apb(1, 12'h000, 32'hC);
    stp = 5;
    apb(1, 12'h00C, 32'hA);
    sh = 10;
    apb(1, 12'h004, 32'd330);
    bs = 330;
    see();
    apb(1, 12'h020, 32'h1);
    bs = 210;
    see();
    apb(1, 12'h000, 32'h4);
    apb(1, 12'h020, 32'h2);
    sh = 0;
    see();
    apb(1, 12'h00C, 32'h3);
    apb(1, 12'h004, 32'd220);
    bs = 220;
    see();
    apb(1, 12'h020, 32'h4);
    bs = 210;
    see();
    apb(1, 12'h000, 32'h11);
    stp = 1;
    apb(1, 12'h004, 32'd240);
    bs = 240;
    see();
    chk(n_nv, 1);
    chk(ext_u.n_tx, 0);
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    see();
    apb(0, 12'h004, 32'h0);
    chk(rd, 0);
    apb(0, 12'h024, 32'h0);
    chk(rd, 240);
    apb(1, 12'h000, 32'h12);
    apb(1, 12'h00C, 32'h5);
    apb(1, 12'h008, 32'd250);
    bs = 250;
    see();
    chk(ext_u.last_tx, 250);
    apb(0, 12'h030, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    final_report();
  end
endmodule
